// ==== src/cfsp_core.sv ====
// cpu condition flags and stack pointer with context stacking
`timescale 1ns/1ps
module cfsp_core (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        srst,
   // alu result update
   input  wire logic        alu_valid,
   input  wire logic [7:0]  alu_result,
   input  wire logic        alu_is_add,
   input  wire logic        alu_half_carry,
   input  wire logic        alu_carry_upd,
   input  wire logic        alu_carry,
   // carry instructions
   input  wire logic        set_carry_instr,
   input  wire logic        reset_carry_instr,
   // level instructions
   input  wire logic        enable_interrupts_instr,
   input  wire logic        disable_interrupts_instr,
   input  wire logic        halt_instr,
   input  wire logic        wait_for_interrupt_instr,
   // interrupt entry and return
   input  wire logic        int_entry,
   input  wire logic [1:0]  vector_priority_regs,
   input  wire logic        interrupt_return_instr,
   // call and return
   input  wire logic        call_instr,
   input  wire logic        ret_instr,
   // single byte push and pop
   input  wire logic        push_byte,
   input  wire logic        pop_byte,
   input  wire logic        pop_to_flags,
   input  wire logic [7:0]  push_data,
   // stack pointer access
   input  wire logic        reset_stack_instr,
   input  wire logic        load_instr,
   input  wire logic [7:0]  load_data,
   // context sources
   input  wire logic [15:0] pc_in,
   input  wire logic [7:0]  x_in,
   input  wire logic [7:0]  a_in,
   // stack memory port
   input  wire logic [7:0]  mem_rdata,
   output logic             mem_we,
   output logic             mem_re,
   output logic [15:0]      mem_addr,
   output logic [7:0]       mem_wdata,
   // context restore
   output logic             ctx_valid,
   output logic [2:0]       ctx_sel,
   output logic [7:0]       ctx_data,
   // register views
   output logic [7:0]       condition_flags,
   output logic [15:0]      stack_pointer,
   output logic [7:0]       stack_low,
   output logic             busy
);
   typedef struct packed {
      logic [7:0] cc;
      logic [6:0] sp;
      logic       pop_rd;
      logic [2:0] pop_sel;
      logic       pop_cc;
      logic       ctx_v;
      logic [2:0] ctx_s;
      logic [7:0] ctx_d;
   } cfsp_core_s;
   cfsp_core_s cur, next_cur;

   logic       seq_busy;
   logic       seq_push;
   logic [2:0] seq_idx;
   logic       seq_step;
   logic       start_push;
   logic       start_pop;
   logic [2:0] seq_count;
   logic [1:0] lvl_q;
   logic       int_ent_q;

   // full pointer from the varying bits
   function automatic logic [15:0] sp_full(input logic [6:0] v);
      sp_full = cfsp_pkg::SP_FIXED | {9'h000, v}; // see RULE11
   endfunction

   assign start_push = !seq_busy && (int_entry || call_instr);
   assign start_pop  = !seq_busy && !start_push && (interrupt_return_instr || ret_instr);
   assign seq_count  = (int_entry || interrupt_return_instr) ? 3'(cfsp_pkg::INT_BYTES)
                                                             : 3'(cfsp_pkg::CALL_BYTES); // see RULE16

   cfsp_ctx_seq u_seq (
      .clk        (clk),
      .srst       (srst),
      .start_push (start_push),
      .start_pop  (start_pop),
      .count      (seq_count),
      .busy       (seq_busy),
      .pushing    (seq_push),
      .index      (seq_idx),
      .step       (seq_step)
   );

   // context byte for a push step, pcl first
   always_comb begin
      unique case (seq_idx)
         cfsp_pkg::CTX_PCL: mem_wdata = pc_in[7:0]; // see RULE15
         cfsp_pkg::CTX_PCH: mem_wdata = pc_in[15:8];
         cfsp_pkg::CTX_X:   mem_wdata = x_in; // see RULE17
         cfsp_pkg::CTX_A:   mem_wdata = a_in;
         cfsp_pkg::CTX_CC:  mem_wdata = cur.cc; // see RULE9
         default:           mem_wdata = 8'h00;
      endcase
      if (!seq_busy) mem_wdata = push_data;
   end

   // memory strobes: push writes at sp, pop reads at sp+1
   assign mem_we   = (seq_step && seq_push) || (!seq_busy && push_byte);
   assign mem_re   = (seq_step && !seq_push) || (!seq_busy && pop_byte);
   assign mem_addr = mem_re ? sp_full(cur.sp + 7'h01) : sp_full(cur.sp); // see RULE10

   // flags and pointer next state
   always_comb begin
      next_cur = cur;
      next_cur.pop_rd = mem_re;
      next_cur.pop_sel = seq_busy ? seq_idx : cfsp_pkg::CTX_CC;
      next_cur.pop_cc = seq_busy ? (seq_idx == cfsp_pkg::CTX_CC) : pop_to_flags;
      next_cur.ctx_v = 1'b0;
      // arithmetic flags; untouched flags hold
      if (alu_valid) begin // see RULE20
         next_cur.cc[cfsp_pkg::BIT_N] = alu_result[7]; // see RULE2
         next_cur.cc[cfsp_pkg::BIT_Z] = alu_result == 8'h00; // see RULE3
         if (alu_is_add) next_cur.cc[cfsp_pkg::BIT_H] = alu_half_carry; // see RULE1
      end
      if (alu_carry_upd) next_cur.cc[cfsp_pkg::BIT_C] = alu_carry; // see RULE4
      if (set_carry_instr) next_cur.cc[cfsp_pkg::BIT_C] = 1'b1; // see RULE5
      if (reset_carry_instr) next_cur.cc[cfsp_pkg::BIT_C] = 1'b0; // see RULE5
      // level bits, encoding i1:i0
      if (enable_interrupts_instr || halt_instr || wait_for_interrupt_instr)
         {next_cur.cc[cfsp_pkg::BIT_I1], next_cur.cc[cfsp_pkg::BIT_I0]} = cfsp_pkg::LVL_MAIN; // see RULE8
      if (disable_interrupts_instr)
         {next_cur.cc[cfsp_pkg::BIT_I1], next_cur.cc[cfsp_pkg::BIT_I0]} = cfsp_pkg::LVL_DISABLE; // see RULE6
      // level load happens after the old flags were stacked
      if (seq_busy && seq_push && seq_idx == cfsp_pkg::CTX_CC && cur.pop_cc == 1'b0 && int_ent_q)
         {next_cur.cc[cfsp_pkg::BIT_I1], next_cur.cc[cfsp_pkg::BIT_I0]} = lvl_q; // see RULE7
      // popped byte arrives one cycle after the read
      if (cur.pop_rd) begin
         next_cur.ctx_v = 1'b1;
         next_cur.ctx_s = cur.pop_sel;
         next_cur.ctx_d = mem_rdata;
         if (cur.pop_cc) next_cur.cc = mem_rdata; // see RULE18
      end
      // stack pointer moves, wrapping in seven bits
      if (mem_we) next_cur.sp = cur.sp - 7'h01; // see RULE14
      if (mem_re) next_cur.sp = cur.sp + 7'h01; // see RULE14
      if (load_instr) next_cur.sp = load_data[6:0]; // see RULE13
      if (reset_stack_instr) next_cur.sp = cfsp_pkg::SP_RESET[6:0]; // see RULE12
      next_cur.cc = next_cur.cc | cfsp_pkg::CC_ONES; // see RULE19
   end

   // priority value and entry kind captured at sequence start
   always_ff @(posedge clk) begin
      if (srst) begin
         lvl_q     <= cfsp_pkg::LVL_DISABLE;
         int_ent_q <= 1'b0;
      end else if (start_push || start_pop) begin
         lvl_q     <= vector_priority_regs;
         int_ent_q <= start_push && int_entry;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         cur       <= '0;
         cur.cc    <= cfsp_pkg::CC_RESET;
         cur.sp    <= cfsp_pkg::SP_RESET[6:0]; // see RULE12
      end else begin
         cur <= next_cur;
      end
   end

   assign condition_flags = cur.cc;
   assign stack_pointer   = sp_full(cur.sp);
   assign stack_low       = stack_pointer[7:0];
   assign busy            = seq_busy;
   assign ctx_valid       = cur.ctx_v;
   assign ctx_sel         = cur.ctx_s;
   assign ctx_data        = cur.ctx_d;

   // checks
   property p_nflag;
      @(posedge clk) disable iff (srst) alu_valid |=> condition_flags[cfsp_pkg::BIT_N] == $past(alu_result[7]);
   endproperty
   a_nflag: assert property (p_nflag) else $error("negative flag wrong"); // see RULE2
   property p_zflag;
      @(posedge clk) disable iff (srst) alu_valid |=> condition_flags[cfsp_pkg::BIT_Z] == ($past(alu_result) == 8'h00);
   endproperty
   a_zflag: assert property (p_zflag) else $error("zero flag wrong"); // see RULE3
   property p_hflag;
      @(posedge clk) disable iff (srst) alu_valid && alu_is_add |=> condition_flags[4] == $past(alu_half_carry);
   endproperty
   a_hflag: assert property (p_hflag) else $error("half carry wrong"); // see RULE1
   property p_scf;
      @(posedge clk) disable iff (srst) set_carry_instr && !reset_carry_instr |=> condition_flags[0];
   endproperty
   a_scf: assert property (p_scf) else $error("carry not set"); // see RULE5
   property p_ones;
      @(posedge clk) disable iff (srst) condition_flags[7:6] == 2'h3;
   endproperty
   a_ones: assert property (p_ones) else $error("fixed flag bits not one"); // see RULE19
   property p_upper;
      @(posedge clk) disable iff (srst) stack_pointer[15:7] == 9'h002;
   endproperty
   a_upper: assert property (p_upper) else $error("pointer upper bits moved"); // see RULE11
   property p_rsp;
      @(posedge clk) disable iff (srst) reset_stack_instr |=> stack_pointer == cfsp_pkg::SP_RESET;
   endproperty
   a_rsp: assert property (p_rsp) else $error("pointer not reset"); // see RULE12
   property p_push;
      @(posedge clk) disable iff (srst) mem_we && !load_instr && !reset_stack_instr
         |=> stack_pointer[6:0] == $past(stack_pointer[6:0]) - 7'h01;
   endproperty
   a_push: assert property (p_push) else $error("push did not decrement"); // see RULE14
   property p_int;
      @(posedge clk) disable iff (srst) start_push && int_entry |=> mem_we && mem_wdata == pc_in[7:0] ##1 mem_we[*4];
   endproperty
   a_int: assert property (p_int) else $error("interrupt stacking wrong"); // see RULE16
   c_int: cover property (@(posedge clk) disable iff (srst) start_push && int_entry);
   c_interrupt_return_instr: cover property (@(posedge clk) disable iff (srst) start_pop && interrupt_return_instr);
   c_wrap: cover property (@(posedge clk) disable iff (srst) mem_we && stack_pointer[6:0] == 7'h00);
endmodule

// ==== src/cfsp_ctx_seq.sv ====
// context sequence counter: steps through stacked bytes
`timescale 1ns/1ps
module cfsp_ctx_seq (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        srst,
   // control
   input  wire logic        start_push,
   input  wire logic        start_pop,
   input  wire logic [2:0]  count,
   // state
   output logic             busy,
   output logic             pushing,
   output logic [2:0]       index,
   output logic             step
);
   typedef struct packed {
      cfsp_pkg::cfsp_seq_e st;
      logic [2:0]          idx;
      logic [2:0]          last;
   } cfsp_seq_s;
   cfsp_seq_s cur, next_cur;

   // one byte per cycle while busy
   always_comb begin
      next_cur = cur;
      unique case (cur.st)
         cfsp_pkg::CFSP_IDLE: begin
            next_cur.idx = 3'h0;
            if (start_push) begin
               next_cur.st   = cfsp_pkg::CFSP_PUSH;
               next_cur.last = count - 3'h1;
            end else if (start_pop) begin
               next_cur.st   = cfsp_pkg::CFSP_POP;
               next_cur.last = count - 3'h1;
               next_cur.idx  = count - 3'h1;
            end
         end
         cfsp_pkg::CFSP_PUSH: begin
            if (cur.idx == cur.last) next_cur.st = cfsp_pkg::CFSP_IDLE;
            else next_cur.idx = cur.idx + 3'h1;
         end
         cfsp_pkg::CFSP_POP: begin
            // pop walks the context backwards
            if (cur.idx == 3'h0) next_cur.st = cfsp_pkg::CFSP_IDLE;
            else next_cur.idx = cur.idx - 3'h1;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         cur <= '{cfsp_pkg::CFSP_IDLE, 3'h0, 3'h0};
      end else begin
         cur <= next_cur;
      end
   end

   assign busy    = cur.st != cfsp_pkg::CFSP_IDLE;
   assign pushing = cur.st == cfsp_pkg::CFSP_PUSH;
   assign index   = cur.idx;
   assign step    = busy;
endmodule

// ==== src/cfsp_pkg.sv ====
// constants for the cpu flags and stack pointer block
// Behaviour
// RULE1 - half carry set on bit3 carry in add
// RULE2 - negative flag copies result bit seven
// RULE3 - zero flag set when result is zero
// RULE4 - carry flag shows arithmetic overflow or underflow
// RULE5 - carry also set by scf rcf, shifts, bit-test
// RULE6 - level bits five and three encode priority
// RULE7 - interrupt entry loads level from priority registers
// RULE8 - level bits changed by rim sim interrupt_return_instr halt wfi pop
// RULE9 - whole flag byte pushed and popped
// RULE10 - pointer decrements after push, increments before pop
// RULE11 - upper nine pointer bits fixed by hardware
// RULE12 - reset or rsp instruction loads 017F
// RULE13 - pointer low byte loadable and readable directly
// RULE14 - pointer wraps silently at both limits
// RULE15 - interrupt stacking writes program counter low first
// RULE16 - call uses two bytes, interrupt five
// RULE17 - interrupt context is pc, x, a, flags
// RULE18 - interrupt return restores context including level bits
// RULE19 - flag bits seven and six read one
// RULE20 - flags hold when instruction does not update them
package cfsp_pkg;
   localparam logic [15:0] SP_RESET     = 16'h017F;
   localparam logic [15:0] SP_FIXED     = 16'h0100;
   localparam int          SP_VAR_W     = 7;
   localparam logic [7:0]  CC_RESET     = 8'hEA;
   localparam logic [7:0]  CC_ONES      = 8'hC0;
   localparam int          BIT_C        = 0;
   localparam int          BIT_Z        = 1;
   localparam int          BIT_N        = 2;
   localparam int          BIT_I0       = 3;
   localparam int          BIT_H        = 4;
   localparam int          BIT_I1       = 5;
   localparam int          CALL_BYTES   = 2;
   localparam int          INT_BYTES    = 5;
   localparam logic [1:0]  LVL_MAIN     = 2'h2;
   localparam logic [1:0]  LVL_DISABLE  = 2'h3;
   // stack context byte select, pushed in this order
   localparam logic [2:0]  CTX_PCL      = 3'h0;
   localparam logic [2:0]  CTX_PCH      = 3'h1;
   localparam logic [2:0]  CTX_X        = 3'h2;
   localparam logic [2:0]  CTX_A        = 3'h3;
   localparam logic [2:0]  CTX_CC       = 3'h4;
   typedef enum logic [1:0] {CFSP_IDLE, CFSP_PUSH, CFSP_POP} cfsp_seq_e;
endpackage

// ==== tb/cfsp_stack_ram.sv ====
// stack memory model standing beside the core, registered read
`timescale 1ns/1ps
module cfsp_stack_ram (
   // clock
   input  wire logic        clk,
   // stack port
   input  wire logic        mem_we,
   input  wire logic        mem_re,
   input  wire logic [15:0] mem_addr,
   input  wire logic [7:0]  mem_wdata,
   output logic [7:0]       mem_rdata
);
   logic [7:0] mem [0:511];
   initial mem_rdata = 8'h5A;
   // data only good the cycle after a read; flips otherwise so stale bytes never match
   always @(posedge clk) begin
      if (mem_we)
         mem[mem_addr[8:0]] <= mem_wdata;
      if (mem_re)
         mem_rdata <= mem[mem_addr[8:0]];
      else
         mem_rdata <= ~mem_rdata;
   end
endmodule

// ==== tb/tb_cpu_flags_and_stack_pointer.sv ====
// self-checking bench for the flags and stack pointer block
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; $display("wrong value at %0t: %h not %h", $time, a, b); end end
`define GO(s) begin s <= 1'b1; @(posedge clk); s <= 1'b0; end
`define PULSE(s) begin @(posedge clk); `GO(s) end
module tb_cpu_flags_and_stack_pointer;
   logic        clk = 0, srst = 1, alu_valid = 0, alu_is_add = 0, alu_half_carry = 0, alu_carry_upd = 0;
   logic        alu_carry = 0, set_carry_instr = 0, reset_carry_instr = 0, enable_interrupts_instr = 0;
   logic        disable_interrupts_instr = 0, halt_instr = 0, wait_for_interrupt_instr = 0, int_entry = 0;
   logic        interrupt_return_instr = 0, call_instr = 0, ret_instr = 0, push_byte = 0, pop_byte = 0;
   logic        pop_to_flags = 0, reset_stack_instr = 0, load_instr = 0, mem_we, mem_re, ctx_valid, busy;
   logic [1:0]  vector_priority_regs = 0;
   logic [2:0]  ctx_sel;
   logic [7:0]  alu_result = 0, push_data = 0, load_data = 0, x_in = 0, a_in = 0, mem_rdata, mem_wdata;
   logic [7:0]  ctx_data, condition_flags, stack_low, exp_cc, stk [4][5];
   logic [15:0] pc_in = 0, mem_addr, stack_pointer, exp_sp;
   logic [31:0] rs = 32'hD00A;
   logic [23:0] wq [$], w;
   logic [10:0] rq [$], r;
   int          error_cnt = 0, num_checks = 0;

   cfsp_core DUT (.*);
   cfsp_stack_ram ram (.*);

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // only the low seven pointer bits move, upper ones stay forced
   function automatic logic [15:0] nsp(input logic [15:0] s, input int d);
      return {cfsp_pkg::SP_FIXED[15:7], s[6:0] + d[6:0]};
   endfunction
   task automatic settle();
      int n = 0;
      @(negedge clk);
      while (busy !== 1'b0 && n < 40) begin
         @(negedge clk);
         n++;
      end
   endtask
   // a popped byte lands a little later, so allow a few cycles
   task automatic chk_regs();
      int n = 0;
      while (condition_flags !== exp_cc && n < 3) begin
         @(negedge clk);
         n++;
      end
      `CHK(condition_flags, exp_cc)
      `CHK(stack_pointer, exp_sp)
      `CHK(stack_low, exp_sp[7:0])
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      forever #10 clk = ~clk;
   end
   // watchdog, far beyond the few hundred cycles the tests need
   initial begin
      #(5000 * 20);
      error_cnt++;
      results();
   end
   // result watcher: each stack write, and each restored byte while notes wait, meets the oldest note
   always @(negedge clk) begin
      if (!srst && mem_we) begin
         w = (wq.size() != 0) ? wq.pop_front() : 24'h0;
         `CHK({mem_addr, mem_wdata}, w)
      end
      if (!srst && ctx_valid && rq.size() != 0) begin
         r = rq.pop_front();
         `CHK({ctx_sel, ctx_data}, r)
      end
   end

   initial begin
      exp_cc = cfsp_pkg::CC_RESET;
      exp_sp = cfsp_pkg::SP_RESET;
      repeat (16) @(posedge clk);
      srst <= 1'b0;
      @(negedge clk);
      chk_regs();
      `CHK(condition_flags[7:6], 2'h3)
      $display("test reset done");
      // alu results, the first one zero
      for (int i = 0; i < 12; i++) begin
         rs = lfsr(rs);
         @(posedge clk);
         alu_result <= (i == 0) ? 8'h00 : rs[7:0];
         {alu_is_add, alu_half_carry, alu_carry_upd, alu_carry} <= rs[11:8];
         exp_cc[cfsp_pkg::BIT_N] = (i != 0) & rs[7];
         exp_cc[cfsp_pkg::BIT_Z] = (i == 0) || rs[7:0] == 8'h00;
         if (rs[11]) exp_cc[cfsp_pkg::BIT_H] = rs[10];
         if (rs[9]) exp_cc[cfsp_pkg::BIT_C] = rs[8];
         `GO(alu_valid)
         {alu_is_add, alu_half_carry, alu_carry_upd, alu_carry} <= 4'h0;
         settle();
         chk_regs();
      end
      `PULSE(set_carry_instr)
      exp_cc[cfsp_pkg::BIT_C] = 1'b1;
      settle();
      chk_regs();
      `PULSE(reset_carry_instr)
      exp_cc[cfsp_pkg::BIT_C] = 1'b0;
      settle();
      chk_regs();
      $display("test alu flags done");
      // every level instruction, disable between the others
      for (int k = 0; k < 6; k++) begin
         @(posedge clk);
         case (k)
            0, 2, 4: disable_interrupts_instr <= 1'b1;
            1: enable_interrupts_instr <= 1'b1;
            3: halt_instr <= 1'b1;
            default: wait_for_interrupt_instr <= 1'b1;
         endcase
         @(posedge clk);
         {disable_interrupts_instr, enable_interrupts_instr, halt_instr, wait_for_interrupt_instr} <= 4'h0;
         {exp_cc[5], exp_cc[3]} = (k % 2 == 0) ? cfsp_pkg::LVL_DISABLE : cfsp_pkg::LVL_MAIN;
         settle();
         chk_regs();
      end
      $display("test levels done");
      // byte push, then pop it into the flags
      wq.push_back({exp_sp, 8'h3D});
      exp_sp = nsp(exp_sp, -1);
      @(posedge clk);
      push_data <= 8'h3D;
      `GO(push_byte)
      settle();
      chk_regs();
      @(posedge clk);
      pop_to_flags <= 1'b1;
      `GO(pop_byte)
      pop_to_flags <= 1'b0;
      exp_sp = nsp(exp_sp, 1);
      exp_cc = 8'h3D | cfsp_pkg::CC_ONES;
      settle();
      chk_regs();
      @(posedge clk);
      load_data <= 8'h82;
      `GO(load_instr)
      exp_sp = 16'h0102;
      settle();
      chk_regs();
      $display("test push pop load done");
      // four nested entries crossing the lower limit, then four returns
      for (int p = 0; p < 4; p++) begin
         rs = lfsr(rs);
         stk[p] = '{rs[7:0], rs[15:8], rs[23:16], rs[31:24], exp_cc};
         for (int k = 0; k < 5; k++) wq.push_back({nsp(exp_sp, -k), stk[p][k]});
         @(posedge clk);
         {a_in, x_in, pc_in} <= rs;
         vector_priority_regs <= p[1:0];
         `GO(int_entry)
         exp_sp = nsp(exp_sp, -cfsp_pkg::INT_BYTES);
         {exp_cc[5], exp_cc[3]} = p[1:0];
         settle();
         chk_regs();
      end
      for (int p = 3; p >= 0; p--) begin
         for (int k = 4; k >= 0; k--) rq.push_back({3'(k), stk[p][k]});
         `PULSE(interrupt_return_instr)
         exp_sp = nsp(exp_sp, cfsp_pkg::INT_BYTES);
         exp_cc = stk[p][4];
         settle();
         chk_regs();
      end
      $display("test interrupt nesting done");
      wq.push_back({exp_sp, 8'h34});
      wq.push_back({nsp(exp_sp, -1), 8'h12});
      rq.push_back({cfsp_pkg::CTX_PCH, 8'h12});
      rq.push_back({cfsp_pkg::CTX_PCL, 8'h34});
      @(posedge clk);
      pc_in <= 16'h1234;
      `GO(call_instr)
      exp_sp = nsp(exp_sp, -cfsp_pkg::CALL_BYTES);
      settle();
      chk_regs();
      `PULSE(ret_instr)
      exp_sp = nsp(exp_sp, cfsp_pkg::CALL_BYTES);
      settle();
      chk_regs();
      // last restored byte lands one cycle after the sequence ends
      repeat (3) @(negedge clk);
      `CHK(wq.size() + rq.size(), 0)
      $display("test call return done");
      // reset in mid-run, then a load and the reset-stack instruction
      `PULSE(srst)
      exp_cc = cfsp_pkg::CC_RESET;
      exp_sp = cfsp_pkg::SP_RESET;
      @(negedge clk);
      chk_regs();
      @(posedge clk);
      load_data <= 8'h10;
      `GO(load_instr)
      `PULSE(reset_stack_instr)
      settle();
      chk_regs();
      $display("test resets done");
      results();
   end
endmodule
